// [rtl/cps_pkg.sv]
// Constants and types for the coupler protection sequencer
`default_nettype none
package cps_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned COOL_DELAY_S = 180;
   localparam int unsigned BLOW_PERIOD_S = 7200;
   localparam int unsigned BLOW_RUN_S = 60;
   localparam int unsigned RESTART_S = 10;
   localparam int unsigned QUIET_S = 1800;
   localparam int unsigned CMD_QUAL_MS = 300;
   localparam int unsigned TICK_CYC = CLK_HZ;
   localparam int unsigned QUAL_CYC = (CLK_HZ / 1000) * CMD_QUAL_MS;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] THR_OFF = 8'h04;
   localparam logic [7:0] PROT_OFF = 8'h08;
   localparam logic [7:0] MEAS0_OFF = 8'h0c;
   localparam logic [7:0] MEAS1_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h14;
   localparam logic [7:0] CNT_OFF = 8'h18;
   localparam logic [7:0] ADDR_OFF = 8'h1c;
   localparam logic [7:0] FB_OFF = 8'h20;
   localparam logic [31:0] THR_RST = 32'h00463250;
   localparam logic [31:0] PROT_RST = 32'h00000000;
   localparam logic [6:0] NODE_ADDR_RST = 7'h01;
   localparam logic [7:0] FULL_PCT = 8'h64;
   localparam logic [7:0] FB_BASE = 8'h20;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Protection kinds per variable
   localparam logic [1:0] PROT_DIS = 2'b00;
   localparam logic [1:0] PROT_CYC = 2'b01;
   localparam logic [1:0] PROT_WAIT = 2'b10;
   localparam logic [3:0] CNT_LIM_RST = 4'h8;
   typedef enum logic [2:0] {CPS_ON, CPS_COOL, CPS_OFF, CPS_BLOW, CPS_CYC, CPS_HOLD,
      CPS_FAULT} cps_state_e;
endpackage
`default_nettype wire

// [rtl/cps_top.sv]
// Coupler protection sequencer with AXI4-Lite register slave
// What this block does
// - Entering off asserts the interlock output to hold the exciter in standby.
// - Entering off opens the auxiliary mains relay.
// - After switching off, blowers run for a cooling delay, then stop.
// - While off, blowers run briefly once every two hours.
// - Switching on releases interlock, powers aux mains, restarts blowers.
// - Four threshold comparisons, each output true as closed, false as open.
// - Two compare forward power as power good, one reflected as warning.
// - Thresholds are percent of full scale: 4000W forward, 400W reflected.
// - Threshold edit: select, enter, change, commit only on second enter.
// - Each variable is cyclic with count and limit, wait, or disabled.
// - Foldback level constant until full scale exceeded, then rises with excess.
// - Foldback inputs are forward, reflected, rejected power and temperature.
// - A variable above its maximum forces standby through the interlock.
// - Cyclic alarm restarts after fixed interval; wait alarm when cleared.
// - Temporary shutdown lights wait and reports the causing variable.
// - Cyclic trip bumps its counter; at limit, permanent off with fault.
// - Alarm reset in cyclic standby or fault turns on and clears counters.
// - While transmitting, reset clears counters only with alarm menu shown.
// - Counters clear after half an hour running without alarm.
// - Serial-bus node address is settable, default value 1.
// - Panel changes accepted only in local mode; remote inputs only in remote.
`timescale 1ns/1ps
`default_nettype none
module cps_top #(
   parameter int unsigned TICK_CYC = cps_pkg::TICK_CYC,
   parameter int unsigned QUAL_CYC = cps_pkg::QUAL_CYC
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic local_mode_i,
   input wire logic remote_on_n_i,
   input wire logic remote_off_n_i,
   input wire logic remote_rst_n_i,
   input wire logic alarm_reset_btn_i,
   input wire logic alarm_menu_shown_i,
   output logic interlock_o,
   output logic aux_mains_o,
   output logic blower_o,
   output logic on_led_o,
   output logic wait_led_o,
   output logic fault_led_o,
   output logic foldback_led_o,
   output logic [7:0] foldback_level_o,
   output logic [3:0] set_closed_o,
   output logic [3:0] alarm_cause_o
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   cps_pkg::cps_state_e st_q, st_d;
   logic [31:0] thr_q, thr_d;
   logic [31:0] prot_q, prot_d;
   logic [31:0] meas0_q, meas0_d;
   logic [31:0] meas1_q, meas1_d;
   logic [6:0] node_q, node_d;
   logic [15:0] cnt_q, cnt_d;
   logic [3:0] cause_q, cause_d;
   logic [15:0] sec_q, sec_d;
   logic [15:0] quiet_q, quiet_d;
   logic [24:0] tick_q, tick_d;
   logic [1:0] cmd_q, cmd_d;
   logic [7:0] fb_q, fb_d;
   logic [3:0] set_q, set_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic tick;
   logic [3:0] over;
   logic [7:0] pct [4];
   logic [7:0] excess [4];
   logic any_trip, trip_cyc, trip_wait, cyc_lim, wr_fire;
   logic [2:0] rs1_q, rs2_q;
   logic [2:0] rcmd;
   logic [2:0] rcmd_pend;
   // ----------------------------------------------------------------
   // Remote command qualification
   // ----------------------------------------------------------------
   // Two-flop synchroniser and hold-time qualifier per input
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rs1_q <= 3'h7;
         rs2_q <= 3'h7;
      end
      else
      begin
         rs1_q <= {remote_rst_n_i, remote_off_n_i, remote_on_n_i};
         rs2_q <= rs1_q;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_qual
         logic [23:0] hold_q, hold_d;
         logic done_q, done_d;
         always_comb
         begin
            hold_d = hold_q;
            done_d = done_q;
            if (rs2_q[gi])
            begin
               hold_d = 24'h000000;
               done_d = 1'b0;
            end
            else if (hold_q < 24'(QUAL_CYC))
            begin
               hold_d = hold_q + 24'h000001;
            end
            else
            begin
               done_d = 1'b1;
            end
         end
         always_ff @(posedge clk_sys_i)
         begin
            if (rst_i)
            begin
               hold_q <= 24'h000000;
               done_q <= 1'b0;
            end
            else
            begin
               hold_q <= hold_d;
               done_q <= done_d;
            end
         end
         // One pulse once the low level is held long enough
         assign rcmd_pend[gi] = done_d & ~done_q;
         assign rcmd[gi] = rcmd_pend[gi] & ~local_mode_i;
      end
   endgenerate
   // ----------------------------------------------------------------
   // Comparators and foldback
   // ----------------------------------------------------------------
   // Measurements arrive as percent of full scale per variable
   assign pct[0] = meas0_q[7:0];
   assign pct[1] = meas0_q[15:8];
   assign pct[2] = meas0_q[23:16];
   assign pct[3] = meas0_q[31:24];
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_cmp
         assign over[gi] = pct[gi] > meas1_q[8*gi +: 8];
         assign excess[gi] = (pct[gi] > cps_pkg::FULL_PCT) ?
            8'(pct[gi] - cps_pkg::FULL_PCT) : 8'h00;
      end
   endgenerate
   // Set 0,1 forward power good; set 2 reflected warning; set 3 rejected
   always_comb
   begin
      set_d[0] = pct[0] >= thr_q[7:0];
      set_d[1] = pct[0] >= thr_q[15:8];
      set_d[2] = pct[1] >= thr_q[23:16];
      set_d[3] = pct[2] >= thr_q[31:24];
      fb_d = cps_pkg::FB_BASE;
      for (int k = 0; k < 4; k++)
      begin
         if (8'(cps_pkg::FB_BASE + excess[k]) > fb_d)
         begin
            fb_d = 8'(cps_pkg::FB_BASE + excess[k]);
         end
      end
   end
   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   assign tick = (tick_q == 25'(TICK_CYC - 1));
   always_comb
   begin
      any_trip = 1'b0;
      trip_cyc = 1'b0;
      trip_wait = 1'b0;
      cyc_lim = 1'b0;
      cause_d = cause_q;
      for (int k = 3; k >= 0; k--)
      begin
         if (over[k] && prot_q[2*k +: 2] != cps_pkg::PROT_DIS)
         begin
            any_trip = 1'b1;
            cause_d = (st_q == cps_pkg::CPS_ON) ? 4'(1 << k) : cause_q;
            trip_cyc = prot_q[2*k +: 2] == cps_pkg::PROT_CYC;
            trip_wait = prot_q[2*k +: 2] == cps_pkg::PROT_WAIT;
            cyc_lim = trip_cyc && (4'(cnt_q[4*k +: 4] + 4'h1) >= prot_q[8+4*k +: 4]);
         end
      end
   end
   always_comb
   begin
      st_d = st_q;
      sec_d = sec_q;
      quiet_d = quiet_q;
      tick_d = tick ? 25'h0000000 : 25'(tick_q + 25'h1);
      if (tick)
      begin
         sec_d = sec_q + 16'h0001;
      end
      case (st_q)
         cps_pkg::CPS_ON:
         begin
            quiet_d = tick ? quiet_q + 16'h0001 : quiet_q;
            if (quiet_q >= 16'(cps_pkg::QUIET_S))
            begin
               quiet_d = 16'h0000;
            end
            if (any_trip)
            begin
               sec_d = 16'h0000;
               quiet_d = 16'h0000;
               st_d = cyc_lim ? cps_pkg::CPS_FAULT :
                  (trip_cyc ? cps_pkg::CPS_CYC : cps_pkg::CPS_HOLD);
            end
         end
         cps_pkg::CPS_COOL:
         begin
            if (sec_q >= 16'(cps_pkg::COOL_DELAY_S))
            begin
               sec_d = 16'h0000;
               st_d = cps_pkg::CPS_OFF;
            end
         end
         cps_pkg::CPS_OFF:
         begin
            if (sec_q >= 16'(cps_pkg::BLOW_PERIOD_S))
            begin
               sec_d = 16'h0000;
               st_d = cps_pkg::CPS_BLOW;
            end
         end
         cps_pkg::CPS_BLOW:
         begin
            if (sec_q >= 16'(cps_pkg::BLOW_RUN_S))
            begin
               sec_d = 16'h0000;
               st_d = cps_pkg::CPS_OFF;
            end
         end
         cps_pkg::CPS_CYC:
         begin
            if (sec_q >= 16'(cps_pkg::RESTART_S))
            begin
               st_d = cps_pkg::CPS_ON;
            end
         end
         cps_pkg::CPS_HOLD:
         begin
            if (!trip_wait)
            begin
               st_d = cps_pkg::CPS_ON;
            end
         end
         cps_pkg::CPS_FAULT:
         begin
            st_d = cps_pkg::CPS_FAULT;
         end
         default:
         begin
            st_d = cps_pkg::CPS_OFF;
         end
      endcase
      // Operator commands: off, on, then alarm reset
      if ((cmd_q[1] || rcmd[1]) && st_q != cps_pkg::CPS_COOL && st_q != cps_pkg::CPS_OFF
         && st_q != cps_pkg::CPS_BLOW)
      begin
         sec_d = 16'h0000;
         st_d = cps_pkg::CPS_COOL;
      end
      else if ((cmd_q[0] || rcmd[0]) && (st_q == cps_pkg::CPS_COOL ||
         st_q == cps_pkg::CPS_OFF || st_q == cps_pkg::CPS_BLOW))
      begin
         quiet_d = 16'h0000;
         st_d = cps_pkg::CPS_ON;
      end
      else if ((alarm_reset_btn_i && local_mode_i || rcmd[2]) &&
         (st_q == cps_pkg::CPS_CYC || st_q == cps_pkg::CPS_FAULT))
      begin
         quiet_d = 16'h0000;
         st_d = cps_pkg::CPS_ON;
      end
   end
   // Alarm counters; a new trip wins over a clear in the same cycle
   always_comb
   begin
      logic clr;
      clr = 1'b0;
      if ((alarm_reset_btn_i && local_mode_i) || rcmd[2])
      begin
         clr = (st_q == cps_pkg::CPS_CYC || st_q == cps_pkg::CPS_FAULT) ||
            (st_q == cps_pkg::CPS_ON && alarm_menu_shown_i);
      end
      if (st_q == cps_pkg::CPS_ON && quiet_q >= 16'(cps_pkg::QUIET_S))
      begin
         clr = 1'b1;
      end
      cnt_d = clr ? 16'h0000 : cnt_q;
      if (st_q == cps_pkg::CPS_ON && any_trip && trip_cyc)
      begin
         for (int k = 0; k < 4; k++)
         begin
            if (cause_d[k])
            begin
               cnt_d[4*k +: 4] = cnt_q[4*k +: 4] + 4'h1;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   assign s_axi_awready_o = ~aw_q & ~bv_q;
   assign s_axi_wready_o = ~w_q & ~bv_q;
   assign s_axi_arready_o = ~rv_q;
   assign wr_fire = (aw_q | (s_axi_awvalid_i & s_axi_awready_o)) &
      (w_q | (s_axi_wvalid_i & s_axi_wready_o));
   always_comb
   begin
      logic [7:0] wa;
      logic [31:0] wv;
      wa = aw_q ? awa_q : s_axi_awaddr_i;
      wv = w_q ? wd_q : s_axi_wdata_i;
      aw_d = aw_q | (s_axi_awvalid_i & s_axi_awready_o);
      w_d = w_q | (s_axi_wvalid_i & s_axi_wready_o);
      awa_d = (s_axi_awvalid_i & s_axi_awready_o) ? s_axi_awaddr_i : awa_q;
      wd_d = (s_axi_wvalid_i & s_axi_wready_o) ? s_axi_wdata_i : wd_q;
      bv_d = bv_q & ~s_axi_bready_i;
      br_d = br_q;
      thr_d = thr_q;
      prot_d = prot_q;
      meas0_d = meas0_q;
      meas1_d = meas1_q;
      node_d = node_q;
      cmd_d = 2'b00;
      if (wr_fire)
      begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = cps_pkg::RESP_OKAY;
         case (wa)
            // Panel command pulses: bit0 on, bit1 off
            cps_pkg::CTRL_OFF: cmd_d = local_mode_i ? wv[1:0] : 2'b00;
            // Committed threshold write after second enter
            cps_pkg::THR_OFF: thr_d = local_mode_i ? wv : thr_q;
            cps_pkg::PROT_OFF: prot_d = local_mode_i ? wv : prot_q;
            cps_pkg::MEAS0_OFF: meas0_d = wv;
            cps_pkg::MEAS1_OFF: meas1_d = wv;
            cps_pkg::ADDR_OFF: node_d = local_mode_i ? wv[6:0] : node_q;
            default: br_d = cps_pkg::RESP_SLVERR;
         endcase
      end
      rv_d = rv_q & ~s_axi_rready_i;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         rv_d = 1'b1;
         rr_d = cps_pkg::RESP_OKAY;
         case (s_axi_araddr_i)
            cps_pkg::CTRL_OFF: rd_d = 32'h00000000;
            cps_pkg::THR_OFF: rd_d = thr_q;
            cps_pkg::PROT_OFF: rd_d = prot_q;
            cps_pkg::MEAS0_OFF: rd_d = meas0_q;
            cps_pkg::MEAS1_OFF: rd_d = meas1_q;
            cps_pkg::STAT_OFF: rd_d = {21'h000000, set_q, cause_q, 3'(st_q)};
            cps_pkg::CNT_OFF: rd_d = {16'h0000, cnt_q};
            cps_pkg::ADDR_OFF: rd_d = {25'h0000000, node_q};
            cps_pkg::FB_OFF: rd_d = {24'h000000, fb_q};
            default:
            begin
               rd_d = 32'h00000000;
               rr_d = cps_pkg::RESP_SLVERR;
            end
         endcase
      end
   end
   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         st_q <= cps_pkg::CPS_ON;
         thr_q <= cps_pkg::THR_RST;
         prot_q <= cps_pkg::PROT_RST;
         meas0_q <= 32'h00000000;
         meas1_q <= 32'hffffffff;
         node_q <= cps_pkg::NODE_ADDR_RST;
         cnt_q <= 16'h0000;
         cause_q <= 4'h0;
         sec_q <= 16'h0000;
         quiet_q <= 16'h0000;
         tick_q <= 25'h0000000;
         cmd_q <= 2'b00;
         fb_q <= cps_pkg::FB_BASE;
         set_q <= 4'h0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         rv_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h00000000;
         rd_q <= 32'h00000000;
         br_q <= 2'b00;
         rr_q <= 2'b00;
      end
      else
      begin
         st_q <= st_d;
         thr_q <= thr_d;
         prot_q <= prot_d;
         meas0_q <= meas0_d;
         meas1_q <= meas1_d;
         node_q <= node_d;
         cnt_q <= cnt_d;
         cause_q <= cause_d;
         sec_q <= sec_d;
         quiet_q <= quiet_d;
         tick_q <= tick_d;
         cmd_q <= cmd_d;
         fb_q <= fb_d;
         set_q <= set_d;
         aw_q <= aw_d;
         w_q <= w_d;
         bv_q <= bv_d;
         rv_q <= rv_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         br_q <= br_d;
         rr_q <= rr_d;
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign interlock_o = st_q != cps_pkg::CPS_ON;
   assign aux_mains_o = st_q == cps_pkg::CPS_ON;
   assign blower_o = st_q != cps_pkg::CPS_OFF;
   assign on_led_o = st_q == cps_pkg::CPS_ON;
   assign wait_led_o = st_q == cps_pkg::CPS_CYC || st_q == cps_pkg::CPS_HOLD;
   assign fault_led_o = st_q == cps_pkg::CPS_FAULT;
   assign foldback_led_o = fb_q != cps_pkg::FB_BASE;
   assign foldback_level_o = fb_q;
   assign set_closed_o = set_q;
   assign alarm_cause_o = cause_q;
   assign s_axi_bvalid_o = bv_q;
   assign s_axi_bresp_o = br_q;
   assign s_axi_rvalid_o = rv_q;
   assign s_axi_rdata_o = rd_q;
   assign s_axi_rresp_o = rr_q;
endmodule
`default_nettype wire

// [verif/cps_exciter_model.sv]
// Behavioural exciter on the far side of the interlock and foldback lines
`timescale 1ns/1ps
`default_nettype none
module cps_exciter_model
(
   input wire logic clk_sys_i,
   input wire logic interlock_i,
   input wire logic [7:0] fb_level_i,
   output logic emit_o,
   output logic [7:0] drive_o
);
   // Standby while inhibited, drive cut back by the foldback excess
   always_ff @(posedge clk_sys_i)
   begin
      emit_o <= !interlock_i;
      drive_o <= interlock_i ? 8'h00 : cps_pkg::FULL_PCT - (fb_level_i - cps_pkg::FB_BASE);
   end
endmodule
`default_nettype wire

// [verif/cps_top_sva.sv]
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module cps_top_sva
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic interlock_o,
   input wire logic aux_mains_o,
   input wire logic blower_o,
   input wire logic on_led_o,
   input wire logic wait_led_o,
   input wire logic fault_led_o,
   input wire logic foldback_led_o,
   input wire logic [7:0] foldback_level_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // Bus requests answered on the next cycle
   wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |=> s_axi_bvalid_o) else $error("write not answered");
   rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read not answered");
   // Output relations of the sequencer states
   off_inhibit_a: assert property ($rose(interlock_o) |-> !on_led_o)
      else $error("interlock raised while on");
   aux_open_a: assert property ($fell(aux_mains_o) |-> interlock_o)
      else $error("aux opened without interlock");
   cool_stop_a: assert property ($fell(blower_o) |-> interlock_o)
      else $error("blower stopped while on");
   on_release_a: assert property (on_led_o |-> !interlock_o && aux_mains_o && blower_o)
      else $error("on state outputs wrong");
   wait_inhibit_a: assert property (wait_led_o |-> interlock_o)
      else $error("wait without interlock");
   fault_off_a: assert property (fault_led_o |-> interlock_o && !on_led_o)
      else $error("fault without inhibit");
   fb_idle_a: assert property (!foldback_led_o |-> foldback_level_o == cps_pkg::FB_BASE)
      else $error("foldback level moved while idle");
   fb_rise_a: assert property (foldback_led_o |-> foldback_level_o > cps_pkg::FB_BASE)
      else $error("foldback lit without rise");
endmodule
bind cps_top cps_top_sva chk_i (.clk_sys_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
   .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_rvalid_o, .interlock_o, .aux_mains_o, .blower_o, .on_led_o, .wait_led_o,
   .fault_led_o, .foldback_led_o, .foldback_level_o);
`default_nettype wire

// [verif/cps_top_test.sv]
// Self-checking bench for the coupler protection sequencer
`timescale 1ns/1ps
`default_nettype none
module cps_top_test;
   logic clk_sys_i = 1'h0;
   logic rst_i = 1'h1;
   logic [7:0] s_axi_awaddr_i = 8'h00;
   logic [7:0] s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_arvalid_i = 1'h0;
   logic s_axi_bready_i = 1'h1, s_axi_rready_i = 1'h1, local_mode_i = 1'h1;
   logic remote_on_n_i = 1'h1, remote_off_n_i = 1'h1, remote_rst_n_i = 1'h1;
   logic alarm_reset_btn_i = 1'h0, alarm_menu_shown_i = 1'h0;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, bresp, rresp;
   logic [31:0] s_axi_rdata_o, rdat;
   logic interlock_o, aux_mains_o, blower_o, on_led_o, wait_led_o, fault_led_o;
   logic foldback_led_o, emit;
   logic [7:0] foldback_level_o, drive;
   logic [3:0] set_closed_o, alarm_cause_o;
   int miscompares = 0, n_checks = 0, n;
   cps_top #(.TICK_CYC(4), .QUAL_CYC(4)) dut (.*);
   cps_exciter_model exc (.clk_sys_i, .interlock_i(interlock_o), .fb_level_i(foldback_level_o),
      .emit_o(emit), .drive_o(drive));
   // Clock, reset and watchdog
   initial
   begin
      forever #25 clk_sys_i = !clk_sys_i;
   end
   initial
   begin
      #3000000;
      miscompares++;
      print_verdict();
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask
   // Bus master: both channels offered, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'h1;
      s_axi_wvalid_i <= 1'h1;
      do
      begin
         @(posedge clk_sys_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      end while (s_axi_bvalid_o !== 1'h1);
      bresp = s_axi_bresp_o;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'h1;
      do
      begin
         @(posedge clk_sys_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
      end while (s_axi_rvalid_o !== 1'h1);
      rdat = s_axi_rdata_o;
      rresp = s_axi_rresp_o;
   endtask
   // Reset values, node address and unmapped places
   task automatic t_reset;
      chk({interlock_o, aux_mains_o, blower_o, on_led_o}, 4'h7);
      rd(cps_pkg::THR_OFF);
      chk(rdat, cps_pkg::THR_RST);
      rd(cps_pkg::ADDR_OFF);
      chk(rdat & 32'h7f, 32'h1);
      wr(cps_pkg::ADDR_OFF, 32'h5);
      rd(cps_pkg::ADDR_OFF);
      chk(rdat & 32'h7f, 32'h5);
      rd(8'h40);
      chk(rresp, cps_pkg::RESP_SLVERR);
      wr(8'h44, 32'h1);
      chk(bresp, cps_pkg::RESP_SLVERR);
   endtask
   // Threshold contacts and foldback per linked variable
   task automatic t_sets;
      wr(cps_pkg::MEAS0_OFF, 32'h00004b6e);
      cyc(4);
      chk(set_closed_o, 4'hf);
      chk(drive, 8'h5a);
      for (int i = 0; i < 4; i++)
      begin
         wr(cps_pkg::MEAS0_OFF, 32'h6e << (8 * i));
         cyc(4);
         chk({foldback_led_o, foldback_level_o}, 9'h12a);
      end
      wr(cps_pkg::MEAS0_OFF, 32'h00004b3c);
      cyc(4);
      chk(set_closed_o, 4'he);
      chk({foldback_led_o, foldback_level_o}, 9'h020);
   endtask
   // Cyclic trips up to the limit, then alarm reset
   task automatic t_cyc;
      wr(cps_pkg::PROT_OFF, 32'h00000201);
      wr(cps_pkg::MEAS1_OFF, 32'hffffff64);
      wr(cps_pkg::MEAS0_OFF, 32'h0000006e);
      cyc(4);
      chk({interlock_o, wait_led_o, alarm_cause_o}, 6'h31);
      rd(cps_pkg::CNT_OFF);
      chk(rdat & 32'hf, 32'h1);
      cyc(80);
      chk({interlock_o, fault_led_o}, 2'h3);
      wr(cps_pkg::MEAS0_OFF, 32'h3c);
      press();
      chk(on_led_o, 1'h1);
      rd(cps_pkg::CNT_OFF);
      chk(rdat & 32'hf, 32'h0);
   endtask
   // One-cycle press of the alarm reset button
   task automatic press;
      alarm_reset_btn_i <= 1'h1;
      cyc(1);
      alarm_reset_btn_i <= 1'h0;
      cyc(2);
   endtask
   // Alarm reset in cyclic standby and while on, quiet-time clear
   task automatic t_clear;
      wr(cps_pkg::MEAS0_OFF, 32'h6e);
      wr(cps_pkg::MEAS0_OFF, 32'h3c);
      press();
      chk(on_led_o, 1'h1);
      wr(cps_pkg::MEAS0_OFF, 32'h6e);
      wr(cps_pkg::MEAS0_OFF, 32'h3c);
      cyc(50);
      press();
      rd(cps_pkg::CNT_OFF);
      chk(rdat & 32'hf, 32'h1);
      cyc(7300);
      rd(cps_pkg::CNT_OFF);
      chk(rdat & 32'hf, 32'h0);
      wr(cps_pkg::MEAS0_OFF, 32'h6e);
      wr(cps_pkg::MEAS0_OFF, 32'h3c);
      cyc(50);
      alarm_menu_shown_i <= 1'h1;
      press();
      alarm_menu_shown_i <= 1'h0;
      rd(cps_pkg::CNT_OFF);
      chk(rdat & 32'hf, 32'h0);
   endtask
   // Wait-kind hold until cleared, disabled kind never trips
   task automatic t_wait;
      wr(cps_pkg::PROT_OFF, 32'h2);
      wr(cps_pkg::MEAS0_OFF, 32'h6e);
      cyc(100);
      chk({interlock_o, wait_led_o}, 2'h3);
      wr(cps_pkg::MEAS0_OFF, 32'h3c);
      cyc(4);
      chk(on_led_o, 1'h1);
      wr(cps_pkg::PROT_OFF, 32'h0);
      wr(cps_pkg::MEAS0_OFF, 32'h6e);
      cyc(4);
      chk(on_led_o, 1'h1);
      wr(cps_pkg::MEAS0_OFF, 32'h3c);
   endtask
   // Remote mode: bus writes ignored, short pulses ignored
   task automatic t_remote;
      local_mode_i <= 1'h0;
      wr(cps_pkg::CTRL_OFF, 32'h2);
      cyc(3);
      chk(interlock_o, 1'h0);
      remote_off_n_i <= 1'h0;
      cyc(10);
      remote_off_n_i <= 1'h1;
      cyc(3);
      chk(interlock_o, 1'h1);
      remote_on_n_i <= 1'h0;
      cyc(2);
      remote_on_n_i <= 1'h1;
      cyc(8);
      chk(interlock_o, 1'h1);
      remote_on_n_i <= 1'h0;
      cyc(10);
      remote_on_n_i <= 1'h1;
      cyc(3);
      chk(interlock_o, 1'h0);
      local_mode_i <= 1'h1;
   endtask
   // Off, cooling, periodic blower run, back on
   task automatic t_off;
      wr(cps_pkg::CTRL_OFF, 32'h2);
      cyc(3);
      chk({interlock_o, aux_mains_o, blower_o, emit}, 4'ha);
      cyc(700);
      chk(blower_o, 1'h1);
      cyc(40);
      chk(blower_o, 1'h0);
      n = 0;
      while (blower_o !== 1'h1 && n < 30000)
      begin
         cyc(1);
         n++;
      end
      chk(n >= 28000 && n <= 28900, 1'h1);
      cyc(220);
      chk(blower_o, 1'h1);
      cyc(40);
      chk(blower_o, 1'h0);
      wr(cps_pkg::CTRL_OFF, 32'h1);
      cyc(3);
      chk({interlock_o, aux_mains_o, blower_o}, 3'h3);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      cyc(20);
      rst_i <= 1'h0;
      cyc(1);
      t_reset();
      t_sets();
      t_cyc();
      t_clear();
      t_wait();
      t_remote();
      t_off();
      print_verdict();
   end
endmodule
`default_nettype wire
